// *** sfrb_bank23.v ***
// Bank 2 and bank 3 special register decode and storage
`timescale 1ns/100ps
`default_nettype none
`include "sfrb_regs.vh"

// Overview of operation
// RULE1 - Unmapped bank 2/3 addresses read zero and ignore writes.
// RULE2 - Unimplemented bits inside registers always read back zero.
// RULE3 - Upper PC bits only loaded from five-bit holding latch, never accessed.
// RULE4 - Mirrored registers decode at same low offset in every bank.
// RULE5 - Indirect location redirects to address in pointer; holds no storage.
// RULE6 - On 28-pin part, port D/E and direction registers read zero.
// RULE7 - Software keeps parallel-port irq enable and flag clear on 28-pin part.
// RULE8 - Power-on/brown-out and pin/watchdog resets load separate values.
// RULE9 - Software keeps reserved location after nvm control clear.
// RULE10 - Writes through any alias update one physical register.
// RULE11 - ALU flag writes suppressed when flags updated; timeout/power-down read only.
module sfrb_bank23 #(
    parameter PIN_COUNT = 28
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire srst_in,
    input wire power_up_rst_in,
    // Core register access
    input wire [8:0] addr_in,
    input wire wr_en_in,
    input wire rd_en_in,
    input wire [7:0] wr_data_in,
    output reg [7:0] rd_data_out,
    // Core flag updates
    input wire alu_flags_we_in,
    input wire [2:0] alu_flags_in,
    input wire timeout_set_in,
    input wire timeout_clr_in,
    input wire powerdown_set_in,
    input wire powerdown_clr_in,
    // Indirect data memory port
    output wire [8:0] indirect_addr_out,
    output wire indirect_wr_out,
    output wire indirect_rd_out,
    output wire [7:0] indirect_wr_data_out,
    input wire [7:0] indirect_rd_data_in,
    // Program counter interface
    input wire [7:0] pc_low_in,
    output wire pc_low_wr_out,
    output wire [7:0] pc_low_data_out,
    output wire [4:0] pc_high_latch_out,
    // Peripheral state
    input wire [7:0] port_b_pins_in,
    input wire [7:0] timer0_in,
    output wire timer0_wr_out,
    output wire [7:0] port_b_latch_out,
    output wire [7:0] port_b_direction_out,
    output wire [7:0] options_out,
    output wire [7:0] irq_control_out,
    output wire nvm_unlock_wr_out,
    output wire [7:0] nvm_ctrl_out,
    output wire [12:0] nvm_addr_out,
    output wire [13:0] nvm_data_out
);

// ****************************************************************
// Storage
// ****************************************************************
reg [7:0] flags_r;
reg [7:0] pointer_r;
reg [4:0] pch_latch_r;
reg [7:0] irq_r;
reg [7:0] options_r;
reg [7:0] port_b_latch_pins_lat_r;
reg [7:0] port_b_latch_pins_dir_r;
reg [7:0] nvm_dlo_r;
reg [7:0] nvm_alo_r;
reg [7:0] nvm_dhi_r;
reg [7:0] nvm_ahi_r;
reg [7:0] nvm_ctrl_r;
reg [7:0] port_b_sync1_r;
reg [7:0] port_b_sync2_r;
wire [7:0] flags_rst;
wire [7:0] irq_rst;
wire [7:0] nvm_ctrl_rst;

// Pins come from outside the clock domain
always @(posedge ref_clk_in) begin
    port_b_sync1_r <= port_b_pins_in;
    port_b_sync2_r <= port_b_sync1_r;
end

// ****************************************************************
// Decode
// ****************************************************************
function upper_bank;
    input [8:0] a;
    begin
        upper_bank = a[8];
    end
endfunction

function is_mirror;
    input [8:0] a;
    input [6:0] low;
    begin
        is_mirror = (a[6:0] == low); // RULE4
    end
endfunction

wire in_bank = upper_bank(addr_in);
wire hit_ind = is_mirror(addr_in, `SFRB_LOW_INDIRECT);
wire hit_pcl = is_mirror(addr_in, `SFRB_LOW_PCL);
wire hit_flags = is_mirror(addr_in, `SFRB_LOW_FLAGS);
wire hit_ptr = is_mirror(addr_in, `SFRB_LOW_POINTER);
wire hit_pch = is_mirror(addr_in, `SFRB_LOW_PCH_LATCH);
wire hit_irq = is_mirror(addr_in, `SFRB_LOW_IRQ);
wire wr = wr_en_in && in_bank;

// Indirect access redirect, pointer plus bank bit
assign indirect_addr_out = {flags_r[7], pointer_r}; // RULE5
assign indirect_wr_out = wr && hit_ind; // RULE5
assign indirect_rd_out = rd_en_in && in_bank && hit_ind; // RULE5
assign indirect_wr_data_out = wr_data_in;
assign pc_low_wr_out = wr && hit_pcl;
assign pc_low_data_out = wr_data_in;
assign pc_high_latch_out = pch_latch_r; // RULE3
assign timer0_wr_out = wr && (addr_in == `SFRB_OFF_TIMER0);
assign nvm_unlock_wr_out = wr && (addr_in == `SFRB_OFF_NVM_UNLOCK);
assign port_b_latch_out = port_b_latch_pins_lat_r;
assign port_b_direction_out = port_b_latch_pins_dir_r;
assign options_out = options_r;
assign irq_control_out = irq_r;
assign nvm_ctrl_out = nvm_ctrl_r;
assign nvm_addr_out = {nvm_ahi_r[4:0], nvm_alo_r};
assign nvm_data_out = {nvm_dhi_r[5:0], nvm_dlo_r};

// ****************************************************************
// Reset value selection
// ****************************************************************
sfrb_reset_sel #(
    .POR_VAL(`SFRB_RST_FLAGS_POR),
    .OTHER_VAL(`SFRB_RST_ZERO),
    .KEEP_MASK(`SFRB_RST_FLAGS_KEEP)
) u_flags_rst (
    .power_up_in(power_up_rst_in),
    .cur_in(flags_r),
    .val_out(flags_rst)
);

sfrb_reset_sel #(
    .POR_VAL(`SFRB_RST_ZERO),
    .OTHER_VAL(`SFRB_RST_ZERO),
    .KEEP_MASK(`SFRB_RST_IRQ_KEEP)
) u_irq_rst (
    .power_up_in(power_up_rst_in),
    .cur_in(irq_r),
    .val_out(irq_rst)
);

sfrb_reset_sel #(
    .POR_VAL(`SFRB_RST_ZERO),
    .OTHER_VAL(`SFRB_RST_ZERO),
    .KEEP_MASK(`SFRB_RST_NVM_KEEP)
) u_nvm_rst (
    .power_up_in(power_up_rst_in),
    .cur_in(nvm_ctrl_r),
    .val_out(nvm_ctrl_rst)
);

// ****************************************************************
// Register updates
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (srst_in) begin
        flags_r <= flags_rst; // RULE8
        irq_r <= irq_rst; // RULE8
        nvm_ctrl_r <= nvm_ctrl_rst & `SFRB_MASK_NVM_CTRL; // RULE8
        pch_latch_r <= 5'h00;
        options_r <= `SFRB_RST_ONES;
        port_b_latch_pins_dir_r <= `SFRB_RST_ONES;
        // Unknown-at-power-up registers keep contents on any reset
    end else begin
        // One physical copy behind every alias
        if (wr && hit_ptr) begin
            pointer_r <= wr_data_in; // RULE10
        end
        if (wr && hit_pch) begin
            pch_latch_r <= wr_data_in[4:0]; // RULE3
        end
        if (wr && hit_irq) begin
            irq_r <= wr_data_in; // RULE10
        end
        if (wr && (addr_in == `SFRB_OFF_PORT_B_LATCH_PINS)) begin
            port_b_latch_pins_lat_r <= wr_data_in;
        end
        if (wr && (addr_in == `SFRB_OFF_PORT_B_LATCH_PINS_DIR)) begin
            port_b_latch_pins_dir_r <= wr_data_in;
        end
        if (wr && (addr_in == `SFRB_OFF_OPTIONS)) begin
            options_r <= wr_data_in;
        end
        if (wr && (addr_in == `SFRB_OFF_NVM_DATA_LO)) begin
            nvm_dlo_r <= wr_data_in;
        end
        if (wr && (addr_in == `SFRB_OFF_NVM_ADDR_LO)) begin
            nvm_alo_r <= wr_data_in;
        end
        if (wr && (addr_in == `SFRB_OFF_NVM_DATA_HI)) begin
            nvm_dhi_r <= wr_data_in & `SFRB_MASK_NVM_DATA_HI; // RULE2
        end
        if (wr && (addr_in == `SFRB_OFF_NVM_ADDR_HI)) begin
            nvm_ahi_r <= wr_data_in & `SFRB_MASK_NVM_ADDR_HI; // RULE2
        end
        if (wr && (addr_in == `SFRB_OFF_NVM_CTRL)) begin
            // Software may set but not clear WR and RD; error bit is set or cleared by the write
            nvm_ctrl_r <= (wr_data_in & `SFRB_MASK_NVM_CTRL)
                | (nvm_ctrl_r & 8'h03); // RULE2
        end
        // Flags: ALU update beats a software write to the same bits
        flags_r[7:5] <= (wr && hit_flags) ? wr_data_in[7:5] : flags_r[7:5]; // RULE10
        if (alu_flags_we_in) begin
            flags_r[2:0] <= alu_flags_in; // RULE11
        end else if (wr && hit_flags) begin
            flags_r[2:0] <= wr_data_in[2:0]; // RULE11
        end
        // Timeout and power-down only move by core events
        if (timeout_set_in) begin
            flags_r[`SFRB_FLAGS_TIMEOUT] <= 1'b1; // RULE11
        end else if (timeout_clr_in) begin
            flags_r[`SFRB_FLAGS_TIMEOUT] <= 1'b0;
        end
        if (powerdown_set_in) begin
            flags_r[`SFRB_FLAGS_POWERDOWN] <= 1'b1; // RULE11
        end else if (powerdown_clr_in) begin
            flags_r[`SFRB_FLAGS_POWERDOWN] <= 1'b0;
        end
    end
end

// ****************************************************************
// Read mux
// ****************************************************************
always @* begin
    rd_data_out = 8'h00; // RULE1
    if (in_bank) begin
        if (hit_ind) begin
            rd_data_out = indirect_rd_data_in; // RULE5
        end else if (hit_pcl) begin
            rd_data_out = pc_low_in; // RULE4
        end else if (hit_flags) begin
            rd_data_out = flags_r; // RULE4
        end else if (hit_ptr) begin
            rd_data_out = pointer_r;
        end else if (hit_pch) begin
            rd_data_out = {3'b000, pch_latch_r}; // RULE2
        end else if (hit_irq) begin
            rd_data_out = irq_r;
        end else begin
            case (addr_in)
                `SFRB_OFF_TIMER0: rd_data_out = timer0_in;
                `SFRB_OFF_PORT_B_LATCH_PINS: rd_data_out = port_b_sync2_r;
                `SFRB_OFF_NVM_DATA_LO: rd_data_out = nvm_dlo_r;
                `SFRB_OFF_NVM_ADDR_LO: rd_data_out = nvm_alo_r;
                `SFRB_OFF_NVM_DATA_HI: rd_data_out = nvm_dhi_r;
                `SFRB_OFF_NVM_ADDR_HI: rd_data_out = nvm_ahi_r;
                `SFRB_OFF_OPTIONS: rd_data_out = options_r;
                `SFRB_OFF_PORT_B_LATCH_PINS_DIR: rd_data_out = port_b_latch_pins_dir_r;
                `SFRB_OFF_NVM_CTRL: rd_data_out = nvm_ctrl_r;
                // Port D/E never exist in these banks; 28-pin part reads zero
                default: rd_data_out = 8'h00; // RULE1 RULE6
            endcase
        end
    end
end

endmodule // sfrb_bank23

`default_nettype wire

// *** sfrb_bank23_chk.sv ***
// Concurrent checks on the bank 2/3 register file ports
`timescale 1ns/100ps
`default_nettype none
module sfrb_bank23_chk (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Core access
    input wire logic [8:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] rd_data_out,
    input wire logic alu_flags_we_in,
    input wire logic [2:0] alu_flags_in,
    input wire logic timeout_set_in,
    input wire logic timeout_clr_in,
    // Observed outputs
    input wire logic indirect_rd_out,
    input wire logic indirect_wr_out,
    input wire logic [7:0] indirect_rd_data_in,
    input wire logic [4:0] pc_high_latch_out,
    input wire logic [7:0] options_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    wire [6:0] low_w = addr_in[6:0];
    wire ind_w = addr_in[8] && low_w == 7'h00;
    wire flags_w = addr_in[8] && low_w == 7'h03;
    wire latch_w = addr_in[8] && low_w == 7'h0a;
    wire gap_w = addr_in[8] && (low_w[6:4] != 3'h0 || low_w == 7'h05
        || (low_w >= 7'h07 && low_w <= 7'h09) || addr_in[8:1] == 8'hc7);
    // Timeout pulses excluded: they may legally move the bit
    sequence flags_write;
        wr_en_in && flags_w && !timeout_set_in && !timeout_clr_in;
    endsequence
    a_gap_reads_zero: assert property (gap_w |-> rd_data_out == 8'h00)
        else $error("unmapped read not zero");
    a_latch_load: assert property (wr_en_in && latch_w |=>
        {3'h0, pc_high_latch_out} == ($past(wr_data_in) & 8'h1f))
        else $error("pc latch not loaded");
    a_latch_read: assert property (latch_w |-> rd_data_out == {3'h0, pc_high_latch_out})
        else $error("pc latch read wrong");
    a_indirect_read: assert property (rd_en_in && ind_w |->
        indirect_rd_out && rd_data_out == indirect_rd_data_in)
        else $error("indirect read not redirected");
    a_indirect_write: assert property (indirect_wr_out == (wr_en_in && ind_w))
        else $error("indirect write strobe wrong");
    a_timeout_ro: assert property (flags_write ##1 flags_w |->
        (rd_data_out & 8'h10) == ($past(rd_data_out) & 8'h10))
        else $error("timeout flag written");
    a_alu_wins: assert property (flags_write ##0 alu_flags_we_in ##1 flags_w |->
        (rd_data_out & 8'h07) == {5'h00, $past(alu_flags_in)})
        else $error("alu flags lost to write");
    a_reset_loads: assert property ($fell(srst_in) |->
        options_out == 8'hff && pc_high_latch_out == 5'h00)
        else $error("reset values wrong");
    a_data_hi_mask: assert property (addr_in == 9'h10e |-> rd_data_out[7:6] == 2'h0)
        else $error("unimplemented bits set");
endmodule // sfrb_bank23_chk

bind sfrb_bank23 sfrb_bank23_chk chk_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .wr_data_in(wr_data_in),
    .rd_data_out(rd_data_out), .alu_flags_we_in(alu_flags_we_in), .alu_flags_in(alu_flags_in),
    .timeout_set_in(timeout_set_in), .timeout_clr_in(timeout_clr_in),
    .indirect_rd_out(indirect_rd_out), .indirect_wr_out(indirect_wr_out),
    .indirect_rd_data_in(indirect_rd_data_in), .pc_high_latch_out(pc_high_latch_out),
    .options_out(options_out));
`default_nettype wire

// *** sfrb_bank23_tb.sv ***
// Testbench for the bank 2/3 register file
`timescale 1ns/100ps
`default_nettype none
module sfrb_bank23_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pup = 1'b1;
    logic [8:0] a = 9'h000;
    logic we = 1'b0, re = 1'b0, afw = 1'b0, tclr = 1'b0, pclr = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [2:0] afl = 3'h0;
    logic [7:0] rdat, iwd, irdat, pbl;
    logic [8:0] iad;
    logic iwr, ird;
    logic [4:0] pch;
    logic [12:0] nadr;
    logic [13:0] ndat;
    logic plw, t0w, nuw;
    logic [2:0] stb = 3'h0;
    logic [7:0] pbd, opt, irq, nctl;
    int miscompares = 0;
    int tests_run = 0;
    logic [8:0] gaps [9] = '{9'h105, 9'h107, 9'h108, 9'h109, 9'h185, 9'h187, 9'h188, 9'h189,
        9'h18e};

    sfrb_bank23 dut_u (.ref_clk_in(clk), .srst_in(rst), .power_up_rst_in(pup), .addr_in(a),
        .wr_en_in(we), .rd_en_in(re), .wr_data_in(wd), .rd_data_out(rdat),
        .alu_flags_we_in(afw), .alu_flags_in(afl), .timeout_set_in(1'b0),
        .timeout_clr_in(tclr), .powerdown_set_in(1'b0), .powerdown_clr_in(pclr),
        .indirect_addr_out(iad), .indirect_wr_out(iwr), .indirect_rd_out(ird),
        .indirect_wr_data_out(iwd), .indirect_rd_data_in(irdat), .pc_low_in(8'h42),
        .pc_low_wr_out(plw), .pc_low_data_out(), .pc_high_latch_out(pch),
        .port_b_pins_in(8'hc3), .timer0_in(8'h77), .timer0_wr_out(t0w),
        .port_b_latch_out(pbl), .port_b_direction_out(pbd), .options_out(opt),
        .irq_control_out(irq), .nvm_unlock_wr_out(nuw), .nvm_ctrl_out(nctl),
        .nvm_addr_out(nadr), .nvm_data_out(ndat));

    sfrb_mem_model mem_u (.ref_clk_in(clk), .addr_in(iad), .wr_in(iwr), .rd_in(ird),
        .wr_data_in(iwd), .rd_data_out(irdat));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ALU update, when asked, carries the inverse of the written low bits
    task automatic wr(input logic [8:0] ad, input logic [7:0] d, input logic alu);
        @(negedge clk);
        a = ad;
        wd = d;
        we = 1'b1;
        re = 1'b0;
        afw = alu;
        afl = ~d[2:0];
        // Write strobes are combinational; catch them mid-cycle
        #1;
        stb = {plw, t0w, nuw};
        @(negedge clk);
        we = 1'b0;
        afw = 1'b0;
    endtask

    task automatic rd(input logic [8:0] ad, input logic [7:0] e);
        @(negedge clk);
        a = ad;
        re = 1'b1;
        #1;
        check(16'(rdat), 16'(e));
    endtask

    // Whole run needs about 100 cycles
    initial begin
        #(25 * 1000);
        miscompares++;
        complete_run;
    end

    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rd(9'h181, 8'hff);
        rd(9'h186, 8'hff);
        rd(9'h103, 8'h18);
        wr(9'h10a, 8'hff, 1'b0);
        check(16'(pch), 16'h001f);
        rd(9'h18a, 8'h1f);
        foreach (gaps[i]) begin
            wr(gaps[i], 8'hff, 1'b0);
            rd(gaps[i], 8'h00);
        end
        wr(9'h18f, 8'h00, 1'b0);
        rd(9'h18f, 8'h00);
        wr(9'h184, 8'h34, 1'b0);
        rd(9'h104, 8'h34);
        wr(9'h100, 8'ha5, 1'b0);
        check(16'(iad), 16'h0034);
        rd(9'h180, 8'ha5);
        wr(9'h103, 8'h00, 1'b0);
        rd(9'h183, 8'h18);
        wr(9'h183, 8'h00, 1'b1);
        rd(9'h103, 8'h1f);
        @(negedge clk);
        tclr = 1'b1;
        pclr = 1'b1;
        @(negedge clk);
        tclr = 1'b0;
        pclr = 1'b0;
        wr(9'h183, 8'hff, 1'b0);
        rd(9'h103, 8'he7);
        wr(9'h18b, 8'hff, 1'b0);
        rd(9'h10b, 8'hff);
        wr(9'h181, 8'h00, 1'b0);
        check(16'(opt), 16'h0000);
        wr(9'h18c, 8'hff, 1'b0);
        rd(9'h18c, 8'h8f);
        wr(9'h10e, 8'hff, 1'b0);
        wr(9'h10f, 8'hff, 1'b0);
        wr(9'h10d, 8'h12, 1'b0);
        wr(9'h10c, 8'h34, 1'b0);
        check(16'(nadr), 16'h1f12);
        check(16'(ndat), 16'h3f34);
        wr(9'h106, 8'h3c, 1'b0);
        check(16'(pbl), 16'h003c);
        rd(9'h106, 8'hc3);
        rd(9'h101, 8'h77);
        rd(9'h102, 8'h42);
        wr(9'h102, 8'h55, 1'b0);
        check(16'(stb), 16'h0004);
        wr(9'h101, 8'h55, 1'b0);
        check(16'(stb), 16'h0002);
        wr(9'h18d, 8'h55, 1'b0);
        check(16'(stb), 16'h0001);
        // Second reset of the pin/watchdog kind keeps some bits
        @(negedge clk);
        pup = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(9'h103, 8'h07);
        rd(9'h18b, 8'h01);
        rd(9'h18c, 8'h88);
        rd(9'h181, 8'hff);
        rd(9'h10a, 8'h00);
        check(16'(pbd), 16'h00ff);
        check(16'(opt), 16'h00ff);
        check(16'(irq), 16'h0001);
        check(16'(nctl), 16'h0088);
        complete_run;
    end
endmodule // sfrb_bank23_tb
`default_nettype wire

// *** sfrb_mem_model.sv ***
// Data memory model behind the indirect access port
`timescale 1ns/100ps
`default_nettype none
module sfrb_mem_model (
    // Clock
    input wire logic ref_clk_in,
    // Indirect port
    input wire logic [8:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem_r [512];
    logic [7:0] last_r = 8'h00;
    // Idle data inverted so a stale value never passes for an answer
    assign rd_data_out = rd_in ? mem_r[addr_in] : ~last_r;
    always @(posedge ref_clk_in) begin
        if (wr_in) begin
            mem_r[addr_in] <= wr_data_in;
        end
        if (rd_in) begin
            last_r <= mem_r[addr_in];
        end
    end
endmodule // sfrb_mem_model
`default_nettype wire

// *** sfrb_regs.vh ***
// Register offsets, field positions and reset values for the bank 2/3 register file
`ifndef SFRB_REGS_VH
`define SFRB_REGS_VH

// ****************************************************************
// Offsets (9-bit data-memory address)
// ****************************************************************
`define SFRB_OFF_INDIRECT_B2   9'h100
`define SFRB_OFF_TIMER0        9'h101
`define SFRB_OFF_PCL_B2        9'h102
`define SFRB_OFF_FLAGS_B2      9'h103
`define SFRB_OFF_POINTER_B2    9'h104
`define SFRB_OFF_PORT_B_LATCH_PINS         9'h106
`define SFRB_OFF_PCH_LATCH_B2  9'h10a
`define SFRB_OFF_IRQ_B2        9'h10b
`define SFRB_OFF_NVM_DATA_LO   9'h10c
`define SFRB_OFF_NVM_ADDR_LO   9'h10d
`define SFRB_OFF_NVM_DATA_HI   9'h10e
`define SFRB_OFF_NVM_ADDR_HI   9'h10f
`define SFRB_OFF_INDIRECT_B3   9'h180
`define SFRB_OFF_OPTIONS       9'h181
`define SFRB_OFF_PCL_B3        9'h182
`define SFRB_OFF_FLAGS_B3      9'h183
`define SFRB_OFF_POINTER_B3    9'h184
`define SFRB_OFF_PORT_B_LATCH_PINS_DIR     9'h186
`define SFRB_OFF_PCH_LATCH_B3  9'h18a
`define SFRB_OFF_IRQ_B3        9'h18b
`define SFRB_OFF_NVM_CTRL      9'h18c
`define SFRB_OFF_NVM_UNLOCK    9'h18d
`define SFRB_OFF_RESERVED      9'h18f

// Low seven bits shared by every bank
`define SFRB_LOW_INDIRECT      7'h00
`define SFRB_LOW_PCL           7'h02
`define SFRB_LOW_FLAGS         7'h03
`define SFRB_LOW_POINTER       7'h04
`define SFRB_LOW_PCH_LATCH     7'h0a
`define SFRB_LOW_IRQ           7'h0b

// ****************************************************************
// Implemented-bit masks
// ****************************************************************
`define SFRB_MASK_PCH_LATCH    8'h1f
`define SFRB_MASK_NVM_DATA_HI  8'h3f
`define SFRB_MASK_NVM_ADDR_HI  8'h1f
`define SFRB_MASK_NVM_CTRL     8'h8f
`define SFRB_MASK_FLAGS_WR     8'he7
`define SFRB_MASK_ALU_FLAGS    8'h07

// ****************************************************************
// Field positions
// ****************************************************************
`define SFRB_FLAGS_TIMEOUT     4
`define SFRB_FLAGS_POWERDOWN   3
`define SFRB_NVM_WRERR         3
`define SFRB_NVM_WR            1
`define SFRB_NVM_RD            0

// ****************************************************************
// Reset values
// ****************************************************************
`define SFRB_RST_ZERO          8'h00
`define SFRB_RST_ONES          8'hff
`define SFRB_RST_FLAGS_POR     8'h18
`define SFRB_RST_FLAGS_KEEP    8'h1f
`define SFRB_RST_IRQ_KEEP      8'h01
`define SFRB_RST_NVM_KEEP      8'h88

`endif

// *** sfrb_reset_sel.v ***
// Reset value selector: power-up value or other-reset value with kept bits
`timescale 1ns/100ps
`default_nettype none

module sfrb_reset_sel #(
    parameter [7:0] POR_VAL = 8'h00,
    parameter [7:0] OTHER_VAL = 8'h00,
    parameter [7:0] KEEP_MASK = 8'h00
) (
    // Reset kind
    input wire power_up_in,
    // Current register contents
    input wire [7:0] cur_in,
    // Value to load
    output wire [7:0] val_out
);
    // Kept bits hold their present contents on non power-up resets
    assign val_out = power_up_in ? POR_VAL : ((cur_in & KEEP_MASK) | (OTHER_VAL & ~KEEP_MASK));
endmodule // sfrb_reset_sel

`default_nettype wire
